// ---- rtl/dbsc_core.sv ----
// command decoding for block size, sleep and health-monitoring commands
`timescale 1ns/1ps
module dbsc_core
   import dbsc_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [DBSC_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic link_reset_in,
   input wire logic flush_done_in,
   input wire logic spin_done_in,
   input wire logic media_stopped_in,
   input wire logic sector_done_in,
   input wire logic health_done_in,
   input wire logic health_fail_in,
   output logic flush_req,
   output logic spin_down_req,
   output logic iface_active,
   output logic health_req,
   output logic [7:0] health_subcmd,
   output logic block_irq,
   output logic multi_active
);
   // ---------------------------------------------
   // state
   // ---------------------------------------------
   typedef struct packed {
      dbsc_state_t st;
      logic [7:0] feature;
      logic [7:0] count;
      logic [7:0] blk_size;
      logic multi_en;
      logic abort;
      logic err;
      logic seek_ok;
      logic [8:0] remain;
      logic [7:0] blk_cnt;
      logic sect_prev;
      logic irq;
      logic health_go;
      logic [7:0] subcmd;
   } dbsc_core_t;
   dbsc_core_t s_r, s_nxt;

   dbsc_reg_if rif ();
   logic [DBSC_PIN_W-1:0] pins_raw, pins;
   logic link_rst, flush_done, spin_done, stopped, sect_lvl, h_done;
   logic h_fail_q0, h_fail_q1;
   logic cmd_wr, ctl_srst, size_ok, sect_pulse;
   logic st_busy, st_ready, blk_end, last_sect;

   // ---------------------------------------------
   // bus slave and pin synchronisers
   // ---------------------------------------------
   dbsc_wb_slave u_wb (
      .clock(clock),
      .nrst(nrst),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .rif(rif.slave)
   );

   assign pins_raw = {link_reset_in, flush_done_in, spin_done_in,
                      media_stopped_in, sector_done_in, health_done_in};

   dbsc_sync #(.W(DBSC_PIN_W)) u_sync (
      .clock(clock),
      .nrst(nrst),
      .d(pins_raw),
      .q(pins)
   );

   dbsc_sync #(.W(1)) u_sync_fail (
      .clock(clock),
      .nrst(nrst),
      .d(health_fail_in),
      .q(h_fail_q0)
   );

   // fail is synchronised alongside done, so both land together
   assign h_fail_q1 = h_fail_q0;
   assign {link_rst, flush_done, spin_done, stopped, sect_lvl, h_done} = pins;

   // ---------------------------------------------
   // register decode
   // ---------------------------------------------
   assign cmd_wr = rif.wr_stb & (rif.addr == DBSC_OFS_COMMAND);
   // control writes are decoded in every state so sleep can be left
   assign ctl_srst = rif.wr_stb & (rif.addr == DBSC_OFS_CONTROL)
                     & rif.wdata[DBSC_CTL_SRST_BIT];
   // sector edges arrive two cycles late through the synchroniser
   assign sect_pulse = sect_lvl & ~s_r.sect_prev;
   // block ends on the programmed count or on the final sector
   assign blk_end = ((s_r.blk_cnt + 8'h01) == s_r.blk_size) || last_sect;
   assign last_sect = (s_r.remain == 9'h001);

   // allowed block sizes
   always_comb begin
      case (s_r.count)
         DBSC_BS_0: size_ok = 1'b1;
         DBSC_BS_1: size_ok = 1'b1;
         DBSC_BS_2: size_ok = 1'b1;
         DBSC_BS_4: size_ok = 1'b1;
         DBSC_BS_8: size_ok = 1'b1;
         DBSC_BS_16: size_ok = 1'b1;
         default: size_ok = 1'b0;
      endcase
   end

   // ---------------------------------------------
   // status and error readback
   // ---------------------------------------------
   // busy covers every multi-cycle command; sleep reads ready
   assign st_busy = (s_r.st != DBSC_IDLE) && (s_r.st != DBSC_SLEEP);
   assign st_ready = ~st_busy;

   always_comb begin
      logic [7:0] st_byte;
      logic [7:0] err_byte;
      st_byte = 8'h00;
      err_byte = 8'h00;
      st_byte[DBSC_ST_BUSY_BIT] = st_busy;
      st_byte[DBSC_ST_READY_BIT] = st_ready;
      st_byte[DBSC_ST_SEEK_BIT] = s_r.seek_ok;
      st_byte[DBSC_ST_ERR_BIT] = s_r.err;
      err_byte[DBSC_ERR_ABORT_BIT] = s_r.abort;
      case (rif.addr)
         DBSC_OFS_FEATURE: rif.rdata = s_r.feature;
         DBSC_OFS_SECT_CNT: rif.rdata = s_r.count;
         DBSC_OFS_ERROR: rif.rdata = err_byte;
         DBSC_OFS_STATUS: rif.rdata = st_byte;
         DBSC_OFS_BLK_SIZE: rif.rdata = s_r.blk_size;
         default: rif.rdata = 8'h00;
      endcase
   end

   // ---------------------------------------------
   // command sequencer
   // ---------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.sect_prev = sect_lvl;
      s_nxt.irq = 1'b0;
      s_nxt.health_go = 1'b0;
      if (rif.wr_stb && (s_r.st == DBSC_IDLE)) begin
         // task-file loads, sector count before opcode
         if (rif.addr == DBSC_OFS_FEATURE) begin
            s_nxt.feature = rif.wdata;
         end
         if (rif.addr == DBSC_OFS_SECT_CNT) begin
            s_nxt.count = rif.wdata;
         end
      end
      case (s_r.st)
         DBSC_IDLE: begin
            if (cmd_wr) begin
               // flags stay until the next command or a reset
               s_nxt.abort = 1'b0;
               s_nxt.err = 1'b0;
               case (rif.wdata)
                  DBSC_OP_SET_MULT: begin
                     if (size_ok) begin
                        s_nxt.blk_size = s_r.count;
                        s_nxt.multi_en = (s_r.count != DBSC_BS_0);
                        s_nxt.seek_ok = 1'b1;
                     end else begin
                        s_nxt.blk_size = DBSC_BS_RESET;
                        s_nxt.multi_en = 1'b0;
                        s_nxt.abort = 1'b1;
                        s_nxt.err = 1'b1;
                     end
                  end
                  DBSC_OP_SLEEP, DBSC_OP_SLEEP_ALT: begin
                     s_nxt.st = DBSC_FLUSH;
                  end
                  DBSC_OP_HEALTH: begin
                     s_nxt.subcmd = s_r.feature;
                     s_nxt.health_go = 1'b1;
                     s_nxt.st = DBSC_HEALTH;
                  end
                  DBSC_OP_READ_MULT, DBSC_OP_WRITE_MULT: begin
                     if (s_r.multi_en) begin
                        // count of zero asks for a full run of sectors
                        s_nxt.remain = (s_r.count == 8'h00) ? DBSC_FULL_XFER
                                       : {1'b0, s_r.count};
                        s_nxt.blk_cnt = 8'h00;
                        s_nxt.st = DBSC_MULTI;
                     end else begin
                        s_nxt.abort = 1'b1;
                        s_nxt.err = 1'b1;
                     end
                  end
                  default: begin
                     s_nxt.abort = 1'b1;
                     s_nxt.err = 1'b1;
                  end
               endcase
            end
         end
         DBSC_FLUSH: begin
            if (flush_done) begin
               s_nxt.st = stopped ? DBSC_SLEEP : DBSC_SPIN;
            end
         end
         DBSC_SPIN: begin
            if (spin_done) begin
               s_nxt.st = DBSC_SLEEP;
            end
         end
         DBSC_SLEEP: begin
            // only the reset branch below leaves sleep
            s_nxt.seek_ok = 1'b1;
         end
         DBSC_HEALTH: begin
            if (h_done) begin
               // verdict of the far side decides the abort flags
               s_nxt.abort = h_fail_q1;
               s_nxt.err = h_fail_q1;
               s_nxt.seek_ok = 1'b1;
               s_nxt.st = DBSC_IDLE;
            end
         end
         DBSC_MULTI: begin
            if (sect_pulse) begin
               if (blk_end) begin
                  s_nxt.irq = 1'b1;
                  s_nxt.blk_cnt = 8'h00;
               end else begin
                  s_nxt.blk_cnt = s_r.blk_cnt + 8'h01;
               end
               s_nxt.remain = s_r.remain - 9'h001;
               if (last_sect) begin
                  s_nxt.st = DBSC_IDLE;
               end
            end
         end
         default: s_nxt.st = DBSC_IDLE;
      endcase
      // reset outranks the state and abort flags of a command written in the same cycle; its other loads still land
      // only resets leave sleep
      if (ctl_srst || link_rst) begin
         s_nxt.st = DBSC_IDLE;
         s_nxt.abort = 1'b0;
         s_nxt.err = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   assign flush_req = (s_r.st == DBSC_FLUSH);
   assign spin_down_req = (s_r.st == DBSC_SPIN);
   assign iface_active = (s_r.st != DBSC_SLEEP);
   assign health_req = s_r.health_go;
   assign health_subcmd = s_r.subcmd;
   assign block_irq = s_r.irq;
   assign multi_active = (s_r.st == DBSC_MULTI);
endmodule

// ---- rtl/dbsc_pkg.sv ----
// constants and types shared by the block-size / sleep command logic
package dbsc_pkg;
   // ---------------------------------------------
   // register byte offsets
   // ---------------------------------------------
   localparam logic [5:0] DBSC_OFS_FEATURE = 6'h00;
   localparam logic [5:0] DBSC_OFS_SECT_CNT = 6'h04;
   localparam logic [5:0] DBSC_OFS_COMMAND = 6'h08;
   localparam logic [5:0] DBSC_OFS_ERROR = 6'h0C;
   localparam logic [5:0] DBSC_OFS_STATUS = 6'h10;
   localparam logic [5:0] DBSC_OFS_BLK_SIZE = 6'h14;
   localparam logic [5:0] DBSC_OFS_CONTROL = 6'h18;
   localparam int DBSC_ADR_W = 6;
   // ---------------------------------------------
   // command opcodes
   // ---------------------------------------------
   localparam logic [7:0] DBSC_OP_SET_MULT = 8'hC6;
   localparam logic [7:0] DBSC_OP_SLEEP = 8'hE6;
   localparam logic [7:0] DBSC_OP_SLEEP_ALT = 8'h99;
   localparam logic [7:0] DBSC_OP_HEALTH = 8'hB0;
   localparam logic [7:0] DBSC_OP_READ_MULT = 8'hC4;
   localparam logic [7:0] DBSC_OP_WRITE_MULT = 8'hC5;
   // ---------------------------------------------
   // field positions and allowed block sizes
   // ---------------------------------------------
   localparam int DBSC_ERR_ABORT_BIT = 2;
   localparam int DBSC_ST_BUSY_BIT = 7;
   localparam int DBSC_ST_READY_BIT = 6;
   localparam int DBSC_ST_SEEK_BIT = 4;
   localparam int DBSC_ST_ERR_BIT = 0;
   localparam int DBSC_CTL_SRST_BIT = 0;
   localparam logic [7:0] DBSC_BS_0 = 8'h00;
   localparam logic [7:0] DBSC_BS_1 = 8'h01;
   localparam logic [7:0] DBSC_BS_2 = 8'h02;
   localparam logic [7:0] DBSC_BS_4 = 8'h04;
   localparam logic [7:0] DBSC_BS_8 = 8'h08;
   localparam logic [7:0] DBSC_BS_16 = 8'h10;
   localparam logic [7:0] DBSC_BS_RESET = 8'h00;
   localparam logic [8:0] DBSC_FULL_XFER = 9'h100;
   localparam int DBSC_PIN_W = 6;
   // ---------------------------------------------
   // command sequencer states
   // ---------------------------------------------
   typedef enum logic [2:0] {
      DBSC_IDLE = 3'b000,
      DBSC_FLUSH = 3'b001,
      DBSC_SPIN = 3'b010,
      DBSC_SLEEP = 3'b011,
      DBSC_HEALTH = 3'b100,
      DBSC_MULTI = 3'b101
   } dbsc_state_t;
endpackage

// ---- rtl/dbsc_reg_if.sv ----
// register access carrier between bus slave and command core
`timescale 1ns/1ps
interface dbsc_reg_if;
   import dbsc_pkg::*;
   logic wr_stb;
   logic [DBSC_ADR_W-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport slave (output wr_stb, output addr, output wdata, input rdata);
   modport core (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ---- rtl/dbsc_sync.sv ----
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module dbsc_sync #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta_r;
      logic [W-1:0] sync_r;
   } dbsc_sync_t;
   dbsc_sync_t s_r, s_nxt;

   always_comb begin
      s_nxt.meta_r = d;
      s_nxt.sync_r = s_r.meta_r;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.sync_r;
endmodule

// ---- rtl/dbsc_wb_slave.sv ----
// classic wishbone slave feeding the byte-wide register carrier
`timescale 1ns/1ps
module dbsc_wb_slave
   import dbsc_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [DBSC_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   dbsc_reg_if.slave rif
);
   typedef struct packed {
      logic ack_r;
      logic [7:0] rdat_r;
   } dbsc_wb_t;
   dbsc_wb_t s_r, s_nxt;
   logic req;

   assign req = wb_cyc_i & wb_stb_i;

   always_comb begin
      s_nxt = s_r;
      // one wait state, ack for one cycle only
      s_nxt.ack_r = req & ~s_r.ack_r;
      if (req & ~s_r.ack_r) begin
         s_nxt.rdat_r = rif.rdata;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // write lands on the edge that samples ack
   assign rif.wr_stb = req & s_r.ack_r & wb_we_i & wb_sel_i[0];
   assign rif.addr = wb_adr_i;
   assign rif.wdata = wb_dat_i[7:0];
   assign wb_ack_o = s_r.ack_r;
   assign wb_dat_o = {24'h000000, s_r.rdat_r};
endmodule

// ---- testbench/dbsc_core_monitor.sv ----
// port-level checker for the command core
`timescale 1ns/1ps
module dbsc_core_monitor
   import dbsc_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic link_reset_in,
   input wire logic flush_req,
   input wire logic spin_down_req,
   input wire logic iface_active,
   input wire logic health_req,
   input wire logic [7:0] health_subcmd,
   input wire logic block_irq,
   input wire logic multi_active
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held over one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_spin_order: assert property (spin_down_req |-> !flush_req && iface_active &&
      ($past(flush_req) || $past(spin_down_req)))
      else $error("spin-down overlaps flush or sleep");
   a_sleep_entry: assert property ($fell(iface_active) |-> $past(flush_req || spin_down_req))
      else $error("sleep entered outside sleep sequence");
   a_wake_cause: assert property ($rose(iface_active) |->
      $past(link_reset_in, 2) || $past(link_reset_in, 3) || $past(link_reset_in, 4) ||
      $past(wb_we_i && wb_ack_o) || $past(wb_we_i && wb_ack_o, 2))
      else $error("woke without reset");
   a_irq_in_multi: assert property (block_irq |-> $past(multi_active) ##1 !block_irq)
      else $error("block interrupt outside transfer");
   a_health_pulse: assert property (health_req |=> !health_req && $stable(health_subcmd))
      else $error("health request not a steady pulse");
endmodule

// ---- testbench/dbsc_media_model.sv ----
// far-side model: cache, spindle, sector and health engines
`timescale 1ns/1ps
module dbsc_media_model (
   input wire logic clock,
   input wire logic nrst,
   input wire logic flush_req,
   input wire logic spin_down_req,
   input wire logic health_req,
   input wire logic multi_active,
   input wire logic stopped_cfg,
   input wire logic fail_cfg,
   input wire logic slow,
   output logic flush_done,
   output logic spin_done,
   output logic media_stopped,
   output logic sector_done,
   output logic health_done,
   output logic health_fail
);
   logic [3:0] wait_r;
   logic [2:0] sect_r;
   logic hpend_r;
   logic ready;
   assign ready = slow ? (wait_r >= 4'hC) : (wait_r >= 4'h2);
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wait_r <= 4'h0;
         sect_r <= 3'h0;
         hpend_r <= 1'b0;
      end else begin
         sect_r <= multi_active ? sect_r + 3'h1 : 3'h0;
         if (health_req) begin
            hpend_r <= 1'b1;
         end else if (wait_r == 4'hF) begin
            hpend_r <= 1'b0;
         end
         wait_r <= (flush_req || spin_down_req || hpend_r) ? wait_r + 4'h1 : 4'h0;
      end
   end
   assign flush_done = flush_req && ready;
   assign spin_done = spin_down_req && ready;
   assign media_stopped = stopped_cfg;
   assign sector_done = multi_active && sect_r[2];
   assign health_done = hpend_r && ready;
   assign health_fail = health_done && fail_cfg;
endmodule

// ---- testbench/drive_block_size_sleep_cmds_tb.sv ----
// self-checking bench for the command core
`timescale 1ns/1ps
module drive_block_size_sleep_cmds_tb;
   import dbsc_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, link_rst = 1'b0;
   logic stopped_cfg = 1'b0, fail_cfg = 1'b0, slow = 1'b0, spin_seen = 1'b0;
   logic [5:0] wb_adr = 6'h00;
   logic [3:0] wb_sel = 4'h0, sel_val = 4'h1;
   logic [31:0] wb_dat = 32'h00000000, wb_rdat;
   logic wb_ack, flush_done, spin_done, media_stopped, sector_done, health_done, health_fail;
   logic flush_req, spin_down_req, iface_active, health_req, block_irq, multi_active;
   logic [7:0] health_subcmd, rd, sub_seen, irq_cnt;
   int err_total = 0, check_count = 0;
   dbsc_core dut (.clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link_reset_in(link_rst),
      .flush_done_in(flush_done), .spin_done_in(spin_done), .media_stopped_in(media_stopped),
      .sector_done_in(sector_done), .health_done_in(health_done),
      .health_fail_in(health_fail), .flush_req(flush_req), .spin_down_req(spin_down_req),
      .iface_active(iface_active), .health_req(health_req), .health_subcmd(health_subcmd),
      .block_irq(block_irq), .multi_active(multi_active));
   dbsc_media_model far (.clock(clock), .nrst(nrst), .flush_req(flush_req),
      .spin_down_req(spin_down_req), .health_req(health_req), .multi_active(multi_active),
      .stopped_cfg(stopped_cfg), .fail_cfg(fail_cfg), .slow(slow), .flush_done(flush_done),
      .spin_done(spin_done), .media_stopped(media_stopped), .sector_done(sector_done),
      .health_done(health_done), .health_fail(health_fail));
   initial forever #2 clock = ~clock;
   always @(posedge clock) begin
      if (block_irq === 1'b1) irq_cnt = irq_cnt + 8'h01;
      if (health_req === 1'b1) sub_seen = health_subcmd;
      if (spin_down_req === 1'b1) spin_seen = 1'b1;
   end
   task report_and_stop;
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         err_total++;
      end
   endtask
   task hang(input string name);
      $display("[ERR] %s expected done seen timeout", name);
      err_total++;
      report_and_stop;
   endtask
   task wb_xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_sel <= sel_val;
      wb_adr <= a;
      wb_dat <= {24'h000000, d};
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      rd = wb_rdat[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_sel <= 4'h0;
      if (wb_ack !== 1'b1) hang("wb ack");
   endtask
   task cmd(input logic [7:0] op, input logic [7:0] cnt);
      wb_xfer(1'b1, DBSC_OFS_SECT_CNT, cnt);
      wb_xfer(1'b1, DBSC_OFS_COMMAND, op);
   endtask
   task result(input logic ab);
      wb_xfer(1'b0, DBSC_OFS_ERROR, 8'h00);
      chk("error", {5'h00, ab, 2'h0}, rd & 8'h04);
      wb_xfer(1'b0, DBSC_OFS_STATUS, 8'h00);
      chk("status", 8'h40 | {7'h00, ab}, rd & 8'hC1);
   endtask
   task wait_idle;
      int n;
      n = 0;
      do begin
         wb_xfer(1'b0, DBSC_OFS_STATUS, 8'h00);
         n++;
      end while (rd[DBSC_ST_BUSY_BIT] !== 1'b0 && n < 1000);
      if (rd[DBSC_ST_BUSY_BIT] !== 1'b0) hang("busy");
   endtask
   task wait_iface(input logic v);
      int n;
      n = 0;
      while (iface_active !== v && n < 300) begin
         @(posedge clock);
         n++;
      end
      chk("iface_active", {7'h00, v}, {7'h00, iface_active});
   endtask
   task t_power_up;
      wb_xfer(1'b0, DBSC_OFS_BLK_SIZE, 8'h00);
      chk("blk_size", DBSC_BS_RESET, rd);
      wb_xfer(1'b0, 6'h3C, 8'h00);
      chk("unmapped", 8'h00, rd);
      cmd(DBSC_OP_READ_MULT, 8'h04);
      result(1'b1);
      sel_val = 4'h0;
      wb_xfer(1'b1, DBSC_OFS_SECT_CNT, 8'h5A);
      sel_val = 4'h1;
      wb_xfer(1'b0, DBSC_OFS_SECT_CNT, 8'h00);
      chk("sect_cnt", 8'h04, rd);
   endtask
   task t_set_mult;
      logic [7:0] sz [8];
      sz = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h00, 8'h03, 8'h11};
      for (int i = 0; i < 8; i++) begin
         cmd(DBSC_OP_SET_MULT, sz[i]);
         result(i > 5);
         wb_xfer(1'b0, DBSC_OFS_BLK_SIZE, 8'h00);
         if (i < 6) chk("blk_size", sz[i], rd);
         if (i > 4) cmd(DBSC_OP_WRITE_MULT, 8'h01);
         if (i > 4) result(1'b1);
      end
      chk("iface_active", 8'h01, {7'h00, iface_active});
   endtask
   task t_multi;
      logic [7:0] bs [4];
      logic [7:0] cnt [4];
      logic [7:0] irqs [4];
      bs = '{8'h04, 8'h02, 8'h01, 8'h10};
      cnt = '{8'h08, 8'h03, 8'h02, 8'h00};
      irqs = '{8'h02, 8'h02, 8'h02, 8'h10};
      for (int i = 0; i < 4; i++) begin
         cmd(DBSC_OP_SET_MULT, bs[i]);
         irq_cnt = 8'h00;
         cmd(i[0] ? DBSC_OP_READ_MULT : DBSC_OP_WRITE_MULT, cnt[i]);
         wait_idle;
         chk("block_irq count", irqs[i], irq_cnt);
         result(1'b0);
      end
   endtask
   task t_health;
      for (int i = 0; i < 2; i++) begin
         fail_cfg <= i[0];
         slow <= i[0];
         wb_xfer(1'b1, DBSC_OFS_FEATURE, i[0] ? 8'hDA : 8'hD0);
         cmd(DBSC_OP_HEALTH, 8'h00);
         wait_idle;
         chk("health_subcmd", i[0] ? 8'hDA : 8'hD0, sub_seen);
         result(i[0]);
      end
      slow <= 1'b0;
   endtask
   task t_sleep;
      spin_seen = 1'b0;
      cmd(DBSC_OP_SLEEP, 8'h00);
      wait_iface(1'b0);
      chk("spin seen", 8'h01, {7'h00, spin_seen});
      cmd(DBSC_OP_SET_MULT, 8'h02);
      repeat (8) @(posedge clock);
      chk("iface_active", 8'h00, {7'h00, iface_active});
      wb_xfer(1'b1, DBSC_OFS_CONTROL, 8'h01);
      wait_iface(1'b1);
      wb_xfer(1'b0, DBSC_OFS_BLK_SIZE, 8'h00);
      chk("blk_size", DBSC_BS_16, rd);
      stopped_cfg <= 1'b1;
      spin_seen = 1'b0;
      cmd(DBSC_OP_SLEEP_ALT, 8'h00);
      wait_iface(1'b0);
      chk("spin seen", 8'h00, {7'h00, spin_seen});
      link_rst <= 1'b1;
      repeat (4) @(posedge clock);
      link_rst <= 1'b0;
      wait_iface(1'b1);
      result(1'b0);
   endtask
   initial begin
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      t_power_up;
      t_set_mult;
      t_multi;
      t_health;
      t_sleep;
      report_and_stop;
   end
endmodule
bind dbsc_core dbsc_core_monitor mon (.clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .link_reset_in(link_reset_in), .flush_req(flush_req), .spin_down_req(spin_down_req),
   .iface_active(iface_active), .health_req(health_req), .health_subcmd(health_subcmd),
   .block_irq(block_irq), .multi_active(multi_active));
